// ### include/sib_pkg.sv
package sib_pkg;
   // Register addresses on the serial control bus
   localparam logic [6:0] SIB_ADDR_POWER_LOCK_STATUS = 7'h01;
   localparam logic [6:0] SIB_ADDR_TUNE_VOLTAGE_LOG = 7'h02;
   localparam logic [6:0] SIB_ADDR_FREQ_COUNT_HIGH_REG = 7'h04;
   localparam logic [6:0] SIB_ADDR_FREQ_COUNT_LOW_REG = 7'h05;
   localparam logic [6:0] SIB_ADDR_JUNCTION_TEMP_REG = 7'h07;
   localparam logic [6:0] SIB_ADDR_INTERRUPT_STATUS_REG = 7'h08;
   localparam logic [6:0] SIB_ADDR_INTERRUPT_ENABLE_REG = 7'h09;
   localparam logic [6:0] SIB_ADDR_INTERRUPT_CLEAR_REG = 7'h0A;
   localparam logic [6:0] SIB_ADDR_INTERRUPT_SET_REG = 7'h0B;

   // Field positions
   localparam int unsigned SIB_BIT_PLL_LOCK = 7;
   localparam int unsigned SIB_BIT_LOCK_FORCED = 6;
   localparam int unsigned SIB_BIT_SUPPLY_DROP = 0;
   localparam int unsigned SIB_TUNE_LSB = 4;
   localparam int unsigned SIB_TUNE_W = 3;
   localparam int unsigned SIB_FREQ_HIGH_W = 6;
   localparam int unsigned SIB_FREQ_LOW_W = 8;
   localparam int unsigned SIB_FREQ_W = 14;
   localparam int unsigned SIB_TEMP_W = 7;
   localparam int unsigned SIB_BIT_MEASURE_DONE = 1;

   // Reset values
   localparam logic SIB_SUPPLY_DROP_RESET = 1'b1;
   localparam logic SIB_IRQ_BIT_RESET = 1'b0;
   localparam logic [7:0] SIB_BYTE_RESET = 8'h00;

   // Temperature code limits
   localparam logic [7:0] SIB_TEMP_SAT_C = 8'h7F;
   localparam logic [6:0] SIB_TEMP_SAT_CODE = 7'h7F;

   // Timing
   localparam int unsigned SIB_CLK_HZ = 40_000_000;
   localparam int unsigned SIB_LOCK_TIMEOUT_MS = 5;
   localparam int unsigned SIB_LOCK_TIMEOUT_CYCLES = SIB_CLK_HZ / 1000 * SIB_LOCK_TIMEOUT_MS;

   // Serial frame: read flag, 7 address bits, 8 data bits
   localparam logic [4:0] SIB_SPI_HDR_BITS = 5'h08;
   localparam logic [4:0] SIB_SPI_FRAME_BITS = 5'h10;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [6:0] addr;
      logic [7:0] data;
   } sib_req_s;

   typedef enum logic [1:0] {
      SIB_LK_SEARCH,
      SIB_LK_LOCKED,
      SIB_LK_FORCED
   } sib_lock_state_e;
endpackage

// ### hdl/sib_spi_slave.sv
`timescale 1ns/10ps
`default_nettype none
module sib_spi_slave
   import sib_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic i_spi_sclk,
   input wire logic i_spi_ss_n,
   input wire logic i_spi_mosi,
   input wire logic [7:0] i_rd_data,
   output sib_req_s o_req,
   output logic o_spi_miso,
   output logic o_spi_miso_oe
);
   logic sclk_q;
   logic [4:0] bit_cnt;
   logic [14:0] shift_in;
   logic is_read;
   logic [7:0] tx;
   logic rise;
   logic fall;

   assign rise = i_spi_sclk & ~sclk_q & ~i_spi_ss_n;
   assign fall = ~i_spi_sclk & sclk_q & ~i_spi_ss_n;

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         sclk_q <= 1'b0;
      end else begin
         sclk_q <= i_spi_sclk;
      end
   end

   // Receive side: count and shift on rising edges
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         bit_cnt <= 5'h00;
         shift_in <= 15'h0000;
         is_read <= 1'b0;
         o_req <= '0;
      end else begin
         o_req.wr <= 1'b0;
         o_req.rd <= 1'b0;
         if (i_spi_ss_n) begin
            bit_cnt <= 5'h00;
         end else if (rise && bit_cnt < SIB_SPI_FRAME_BITS) begin
            shift_in <= {shift_in[13:0], i_spi_mosi};
            bit_cnt <= bit_cnt + 5'h01;
            if (bit_cnt == SIB_SPI_HDR_BITS - 5'h01) begin
               is_read <= shift_in[6];
               o_req.addr <= {shift_in[5:0], i_spi_mosi};
            end
            if (bit_cnt == SIB_SPI_FRAME_BITS - 5'h01 && !is_read) begin
               o_req.wr <= 1'b1;
               o_req.data <= {shift_in[6:0], i_spi_mosi};
            end
         end else if (fall && bit_cnt == SIB_SPI_HDR_BITS && is_read) begin
            o_req.rd <= 1'b1;
            o_req.data <= i_rd_data;
         end
      end
   end

   // Transmit side: change data on falling edges
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         tx <= 8'h00;
         o_spi_miso <= 1'b0;
         o_spi_miso_oe <= 1'b0;
      end else if (i_spi_ss_n) begin
         o_spi_miso_oe <= 1'b0;
         o_spi_miso <= 1'b0;
      end else if (fall && is_read && bit_cnt == SIB_SPI_HDR_BITS) begin
         tx <= {i_rd_data[6:0], 1'b0};
         o_spi_miso <= i_rd_data[7];
         o_spi_miso_oe <= 1'b1;
      end else if (fall && is_read && bit_cnt > SIB_SPI_HDR_BITS) begin
         tx <= {tx[6:0], 1'b0};
         o_spi_miso <= tx[7];
      end
   end
endmodule // sib_spi_slave
`default_nettype wire

// ### hdl/sib_status_irq_bank.sv
// Operation
// - Power status bit 7 shows PLL lock, one while locked.
// - No lock within 5 ms forces lock indication and sets bit 6.
// - Bit 0 flags a supply drop below the reset threshold.
// - Reading the supply-drop flag clears it unless a new drop arrives.
// - Tuning-voltage ADC code shows in bits 6 to 4.
// - Upper six count bits read in bits 5 to 0 of first register.
// - Lower eight count bits read in bits 7 to 0 of second register.
// - Count is high part times 256 plus low part.
// - Temperature code at most 21 below 22 C, saturates 127 C up.
// - Between 22 and 126 C code equals temperature in degrees.
// - Interrupt status bit 1 shows measurement ended.
// - Interrupt enable bit 1 is read-write and enables measurement interrupt.
// - Interrupt clear bit 1 is read-write and clears measurement status.
// - Interrupt set bit 1 is read-write and forces measurement status.
// - Tuning ADC result is valid only while its enable input is one.
`timescale 1ns/10ps
`default_nettype none
module sib_status_irq_bank
   import sib_pkg::*;
#(
   parameter int unsigned LOCK_TIMEOUT_CYCLES = SIB_LOCK_TIMEOUT_CYCLES
) (
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic i_spi_sclk,
   input wire logic i_spi_ss_n,
   input wire logic i_spi_mosi,
   output logic o_spi_miso,
   output logic o_spi_miso_oe,
   input wire logic i_pll_locked,
   input wire logic i_supply_drop,
   input wire logic i_tune_adc_enable,
   input wire logic [2:0] i_tune_adc_code,
   input wire logic [13:0] i_freq_count,
   input wire logic i_measure_done,
   input wire logic [7:0] i_temp_celsius,
   output logic o_irq
);
   localparam int unsigned CW = $clog2(LOCK_TIMEOUT_CYCLES + 1);

   sib_req_s req;
   logic [7:0] rd_data;
   logic [7:0] next_rd_data;
   logic rd_power;

   sib_lock_state_e lock_state;
   logic [CW-1:0] lock_cnt;
   logic pll_lock_flag;
   logic lock_timeout_forced;
   logic supply_drop_flag;
   logic [2:0] tune_code;
   logic [13:0] freq_count;
   logic [5:0] freq_count_high;
   logic [7:0] freq_count_low;
   logic [6:0] junction_temp_code;
   logic [6:0] next_temp_code;
   logic measure_done_status;
   logic measure_done_irq_en;
   logic measure_done_irq_clr;
   logic measure_done_irq_force;
   logic wr_clr_one;
   logic wr_force_one;

   sib_spi_slave u_spi (
      .i_sys_clk(i_sys_clk),
      .i_reset(i_reset),
      .i_spi_sclk(i_spi_sclk),
      .i_spi_ss_n(i_spi_ss_n),
      .i_spi_mosi(i_spi_mosi),
      .i_rd_data(rd_data),
      .o_req(req),
      .o_spi_miso(o_spi_miso),
      .o_spi_miso_oe(o_spi_miso_oe)
   );

   // Lock monitor: timeout after reset forces the lock indication
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         lock_state <= SIB_LK_SEARCH;
         lock_cnt <= '0;
      end else begin
         unique case (lock_state)
            SIB_LK_SEARCH: begin
               if (i_pll_locked) begin
                  lock_state <= SIB_LK_LOCKED;
               end else if (lock_cnt == CW'(LOCK_TIMEOUT_CYCLES - 1)) begin
                  lock_state <= SIB_LK_FORCED;
               end else begin
                  lock_cnt <= lock_cnt + CW'(1);
               end
            end
            SIB_LK_LOCKED: begin
               lock_state <= SIB_LK_LOCKED;
            end
            SIB_LK_FORCED: begin
               lock_state <= SIB_LK_FORCED;
            end
         endcase
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         pll_lock_flag <= 1'b0;
         lock_timeout_forced <= 1'b0;
      end else begin
         pll_lock_flag <= i_pll_locked || (lock_state == SIB_LK_FORCED);
         lock_timeout_forced <= (lock_state == SIB_LK_FORCED);
      end
   end

   // Supply drop flag: set by reset itself, cleared by read, set wins
   assign rd_power = req.rd && (req.addr == SIB_ADDR_POWER_LOCK_STATUS);

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         supply_drop_flag <= SIB_SUPPLY_DROP_RESET;
      end else if (i_supply_drop) begin
         supply_drop_flag <= 1'b1;
      end else if (rd_power) begin
         supply_drop_flag <= 1'b0;
      end
   end

   // Frequency and temperature captured every cycle, tune code captured while enabled and zeroed while disabled
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         tune_code <= 3'h0;
      end else if (i_tune_adc_enable) begin
         tune_code <= i_tune_adc_code;
      end else begin
         tune_code <= 3'h0;
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         freq_count <= 14'h0000;
      end else begin
         freq_count <= i_freq_count;
      end
   end

   assign freq_count_high = freq_count[SIB_FREQ_W-1:SIB_FREQ_LOW_W];
   assign freq_count_low = freq_count[SIB_FREQ_LOW_W-1:0];

   always_comb begin
      if (i_temp_celsius >= SIB_TEMP_SAT_C) begin
         next_temp_code = SIB_TEMP_SAT_CODE;
      end else begin
         next_temp_code = i_temp_celsius[SIB_TEMP_W-1:0];
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         junction_temp_code <= 7'h00;
      end else begin
         junction_temp_code <= next_temp_code;
      end
   end

   // Interrupt control registers
   assign wr_clr_one = req.wr && (req.addr == SIB_ADDR_INTERRUPT_CLEAR_REG)
                       && req.data[SIB_BIT_MEASURE_DONE];
   assign wr_force_one = req.wr && (req.addr == SIB_ADDR_INTERRUPT_SET_REG)
                         && req.data[SIB_BIT_MEASURE_DONE];

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         measure_done_irq_en <= SIB_IRQ_BIT_RESET;
      end else if (req.wr && req.addr == SIB_ADDR_INTERRUPT_ENABLE_REG) begin
         measure_done_irq_en <= req.data[SIB_BIT_MEASURE_DONE];
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         measure_done_irq_clr <= SIB_IRQ_BIT_RESET;
      end else if (req.wr && req.addr == SIB_ADDR_INTERRUPT_CLEAR_REG) begin
         measure_done_irq_clr <= req.data[SIB_BIT_MEASURE_DONE];
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         measure_done_irq_force <= SIB_IRQ_BIT_RESET;
      end else if (req.wr && req.addr == SIB_ADDR_INTERRUPT_SET_REG) begin
         measure_done_irq_force <= req.data[SIB_BIT_MEASURE_DONE];
      end
   end

   // Status: completion or forced set wins over a clear in the same cycle
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         measure_done_status <= SIB_IRQ_BIT_RESET;
      end else if (i_measure_done || wr_force_one) begin
         measure_done_status <= 1'b1;
      end else if (wr_clr_one) begin
         measure_done_status <= 1'b0;
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= measure_done_status && measure_done_irq_en;
      end
   end

   // Read data mux; unmapped and reserved bits read as zero
   always_comb begin
      next_rd_data = SIB_BYTE_RESET;
      unique case (req.addr)
         SIB_ADDR_POWER_LOCK_STATUS: begin
            next_rd_data[SIB_BIT_PLL_LOCK] = pll_lock_flag;
            next_rd_data[SIB_BIT_LOCK_FORCED] = lock_timeout_forced;
            next_rd_data[SIB_BIT_SUPPLY_DROP] = supply_drop_flag;
         end
         SIB_ADDR_TUNE_VOLTAGE_LOG: begin
            next_rd_data[SIB_TUNE_LSB +: SIB_TUNE_W] = tune_code;
         end
         SIB_ADDR_FREQ_COUNT_HIGH_REG: begin
            next_rd_data[SIB_FREQ_HIGH_W-1:0] = freq_count_high;
         end
         SIB_ADDR_FREQ_COUNT_LOW_REG: begin
            next_rd_data = freq_count_low;
         end
         SIB_ADDR_JUNCTION_TEMP_REG: begin
            next_rd_data[SIB_TEMP_W-1:0] = junction_temp_code;
         end
         SIB_ADDR_INTERRUPT_STATUS_REG: begin
            next_rd_data[SIB_BIT_MEASURE_DONE] = measure_done_status;
         end
         SIB_ADDR_INTERRUPT_ENABLE_REG: begin
            next_rd_data[SIB_BIT_MEASURE_DONE] = measure_done_irq_en;
         end
         SIB_ADDR_INTERRUPT_CLEAR_REG: begin
            next_rd_data[SIB_BIT_MEASURE_DONE] = measure_done_irq_clr;
         end
         SIB_ADDR_INTERRUPT_SET_REG: begin
            next_rd_data[SIB_BIT_MEASURE_DONE] = measure_done_irq_force;
         end
         default: begin
            next_rd_data = SIB_BYTE_RESET;
         end
      endcase
   end

   assign rd_data = next_rd_data;
endmodule // sib_status_irq_bank
`default_nettype wire

// ### test/sib_status_irq_bank_props.sv
`timescale 1ns/10ps
`default_nettype none
module sib_status_irq_bank_props
   import sib_pkg::*;
#(
   parameter int unsigned LOCK_TIMEOUT_CYCLES = SIB_LOCK_TIMEOUT_CYCLES
) (
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic i_spi_sclk,
   input wire logic i_spi_ss_n,
   input wire logic i_spi_mosi,
   input wire logic o_spi_miso,
   input wire logic o_spi_miso_oe,
   input wire logic i_pll_locked,
   input wire logic i_supply_drop,
   input wire logic i_tune_adc_enable,
   input wire logic [2:0] i_tune_adc_code,
   input wire logic [13:0] i_freq_count,
   input wire logic i_measure_done,
   input wire logic [7:0] i_temp_celsius,
   input wire logic o_irq
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_reset);
   sequence s_quiet;
      (i_spi_ss_n && !i_measure_done) [*4];
   endsequence
   sequence s_idle;
      i_spi_ss_n [*4];
   endsequence
   irq_start_a: assert property ($fell(i_reset) |-> !o_irq [*2])
      else $error("irq high right after reset");
   irq_hold_a: assert property (s_quiet |=> $stable(o_irq))
      else $error("irq moved without a cause");
   irq_cause_a: assert property ($rose(o_irq) |->
      $past(i_measure_done, 2) || $past(i_measure_done, 3) || !$past(i_spi_ss_n, 2))
      else $error("irq rose without completion or write");
   miso_idle_a: assert property (!o_spi_miso_oe |-> !o_spi_miso)
      else $error("miso not low while released");
   oe_idle_a: assert property (s_idle |-> !o_spi_miso_oe)
      else $error("miso enable high outside frame");
   oe_rise_a: assert property ($rose(o_spi_miso_oe) |-> !i_spi_sclk && !i_spi_ss_n)
      else $error("miso enable rose at wrong time");
   oe_frame_a: assert property (o_spi_miso_oe && !i_spi_ss_n |=> o_spi_miso_oe)
      else $error("miso enable dropped in frame");
   miso_edge_a: assert property ($changed(o_spi_miso) && $past(o_spi_miso_oe) |-> !i_spi_sclk)
      else $error("miso changed while sclk high");
endmodule // sib_status_irq_bank_props

bind sib_status_irq_bank sib_status_irq_bank_props #(
   .LOCK_TIMEOUT_CYCLES(LOCK_TIMEOUT_CYCLES)
) i_props (
   .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_spi_sclk(i_spi_sclk),
   .i_spi_ss_n(i_spi_ss_n), .i_spi_mosi(i_spi_mosi), .o_spi_miso(o_spi_miso),
   .o_spi_miso_oe(o_spi_miso_oe), .i_pll_locked(i_pll_locked),
   .i_supply_drop(i_supply_drop), .i_tune_adc_enable(i_tune_adc_enable),
   .i_tune_adc_code(i_tune_adc_code), .i_freq_count(i_freq_count),
   .i_measure_done(i_measure_done), .i_temp_celsius(i_temp_celsius), .o_irq(o_irq)
);
`default_nettype wire

// ### test/sib_host.sv
`timescale 1ns/10ps
`default_nettype none
module sib_host (
   input wire logic i_sys_clk,
   input wire logic i_spi_miso,
   output logic o_spi_sclk,
   output logic o_spi_ss_n,
   output logic o_spi_mosi
);
   initial begin
      o_spi_sclk = 1'b0;
      o_spi_ss_n = 1'b1;
      o_spi_mosi = 1'b0;
   end
   // One frame, MSB first, four clocks per sclk phase
   task automatic xfer(input logic r, input logic [6:0] a, input logic [7:0] wd,
         output logic [7:0] q);
      logic [15:0] f;
      f = {r, a, wd};
      q = 8'h00;
      @(negedge i_sys_clk);
      o_spi_ss_n = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         o_spi_mosi = f[i];
         repeat (4) @(negedge i_sys_clk);
         if (i < 8) begin
            q[i] = i_spi_miso;
         end
         o_spi_sclk = 1'b1;
         repeat (4) @(negedge i_sys_clk);
         o_spi_sclk = 1'b0;
      end
      repeat (4) @(negedge i_sys_clk);
      o_spi_ss_n = 1'b1;
      o_spi_mosi = ~o_spi_mosi;
      repeat (4) @(negedge i_sys_clk);
   endtask
   // Deselect after n bits; the partial frame must be dropped
   task automatic cut(input logic [15:0] f, input int n);
      @(negedge i_sys_clk);
      o_spi_ss_n = 1'b0;
      for (int i = 15; i > 15 - n; i--) begin
         o_spi_mosi = f[i];
         repeat (4) @(negedge i_sys_clk);
         o_spi_sclk = 1'b1;
         repeat (4) @(negedge i_sys_clk);
         o_spi_sclk = 1'b0;
      end
      repeat (4) @(negedge i_sys_clk);
      o_spi_ss_n = 1'b1;
      repeat (4) @(negedge i_sys_clk);
   endtask
endmodule // sib_host
`default_nettype wire

// ### test/sib_status_irq_bank_test.sv
`timescale 1ns/10ps
`default_nettype none
module sib_status_irq_bank_test
   import sib_pkg::*;
;
   typedef struct packed {
      logic [7:0] temp;
      logic [6:0] code;
      logic [2:0] adc;
      logic [13:0] cnt;
   } sib_row_s;
   sib_row_s rows [8] = '{{8'h00, 7'h00, 3'h0, 14'h0000}, {8'h15, 7'h15, 3'h1, 14'h3FFF},
      {8'h16, 7'h16, 3'h2, 14'h2A55}, {8'h40, 7'h40, 3'h3, 14'h1234},
      {8'h7E, 7'h7E, 3'h4, 14'h00FF}, {8'h7F, 7'h7F, 3'h5, 14'h0100},
      {8'h80, 7'h7F, 3'h6, 14'h3F00}, {8'hFF, 7'h7F, 3'h7, 14'h15AA}};
   logic clk, rst, sclk, ss_n, mosi, miso, miso_oe, lock, drop, adc_en, mdone, irq;
   logic miso_line;
   logic [2:0] adc;
   logic [13:0] cnt;
   logic [7:0] temp, rd;
   int miscompares = 0;
   int checks_done = 0;
   // Released line shows the inverse so a missing enable is caught
   assign miso_line = miso_oe ? miso : ~miso;
   sib_status_irq_bank #(.LOCK_TIMEOUT_CYCLES(20)) i_dut (
      .i_sys_clk(clk), .i_reset(rst), .i_spi_sclk(sclk), .i_spi_ss_n(ss_n),
      .i_spi_mosi(mosi), .o_spi_miso(miso), .o_spi_miso_oe(miso_oe),
      .i_pll_locked(lock), .i_supply_drop(drop), .i_tune_adc_enable(adc_en),
      .i_tune_adc_code(adc), .i_freq_count(cnt), .i_measure_done(mdone),
      .i_temp_celsius(temp), .o_irq(irq));
   sib_host i_host (.i_sys_clk(clk), .i_spi_miso(miso_line), .o_spi_sclk(sclk),
      .o_spi_ss_n(ss_n), .o_spi_mosi(mosi));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      chk8({7'h00, got}, {7'h00, exp});
   endtask
   task automatic rdr(input logic [6:0] a, input logic [7:0] exp);
      i_host.xfer(1'b1, a, 8'h00, rd);
      chk8(rd, exp);
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      i_host.xfer(1'b0, a, d, rd);
   endtask
   task automatic do_reset;
      rst = 1'b1;
      repeat (4) @(negedge clk);
      rst = 1'b0;
   endtask
   task automatic finish_test;
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge clk);
      miscompares++;
      finish_test();
   end
   initial begin
      {rst, lock, drop, adc_en, mdone, adc, cnt, temp} = '0;
      do_reset();
      adc_en = 1'b1;
      foreach (rows[i]) begin
         {temp, adc, cnt} = {rows[i].temp, rows[i].adc, rows[i].cnt};
         rdr(SIB_ADDR_JUNCTION_TEMP_REG, {1'b0, rows[i].code});
         rdr(SIB_ADDR_TUNE_VOLTAGE_LOG, {1'b0, rows[i].adc, 4'h0});
         rdr(SIB_ADDR_FREQ_COUNT_HIGH_REG, {2'b00, rows[i].cnt[13:8]});
         rdr(SIB_ADDR_FREQ_COUNT_LOW_REG, rows[i].cnt[7:0]);
      end
      rdr(SIB_ADDR_POWER_LOCK_STATUS, 8'hC1);
      rdr(SIB_ADDR_POWER_LOCK_STATUS, 8'hC0);
      lock = 1'b1;
      do_reset(); // Full reinit after the drop was seen
      rdr(SIB_ADDR_POWER_LOCK_STATUS, 8'h81);
      rdr(SIB_ADDR_POWER_LOCK_STATUS, 8'h80);
      drop = 1'b1;
      @(negedge clk);
      drop = 1'b0;
      rdr(SIB_ADDR_POWER_LOCK_STATUS, 8'h81);
      lock = 1'b0;
      rdr(SIB_ADDR_POWER_LOCK_STATUS, 8'h00);
      adc_en = 1'b0;
      rdr(SIB_ADDR_TUNE_VOLTAGE_LOG, 8'h00);
      rdr(7'h03, 8'h00);
      rdr(SIB_ADDR_INTERRUPT_STATUS_REG, 8'h00);
      mdone = 1'b1;
      @(negedge clk);
      mdone = 1'b0;
      rdr(SIB_ADDR_INTERRUPT_STATUS_REG, 8'h02);
      chk1(irq, 1'b0);
      wr(SIB_ADDR_INTERRUPT_ENABLE_REG, 8'h02);
      rdr(SIB_ADDR_INTERRUPT_ENABLE_REG, 8'h02);
      chk1(irq, 1'b1);
      wr(SIB_ADDR_INTERRUPT_CLEAR_REG, 8'h00);
      rdr(SIB_ADDR_INTERRUPT_STATUS_REG, 8'h02);
      wr(SIB_ADDR_INTERRUPT_CLEAR_REG, 8'h02);
      rdr(SIB_ADDR_INTERRUPT_CLEAR_REG, 8'h02);
      rdr(SIB_ADDR_INTERRUPT_STATUS_REG, 8'h00);
      chk1(irq, 1'b0);
      mdone = 1'b1;
      @(negedge clk);
      mdone = 1'b0;
      rdr(SIB_ADDR_INTERRUPT_STATUS_REG, 8'h02);
      wr(SIB_ADDR_INTERRUPT_CLEAR_REG, 8'h02);
      rdr(SIB_ADDR_INTERRUPT_STATUS_REG, 8'h00);
      wr(SIB_ADDR_INTERRUPT_SET_REG, 8'h02);
      rdr(SIB_ADDR_INTERRUPT_STATUS_REG, 8'h02);
      rdr(SIB_ADDR_INTERRUPT_SET_REG, 8'h02);
      chk1(irq, 1'b1);
      wr(SIB_ADDR_INTERRUPT_STATUS_REG, 8'h00);
      rdr(SIB_ADDR_INTERRUPT_STATUS_REG, 8'h02);
      // Frame cut one bit short must not write
      i_host.cut({1'b0, SIB_ADDR_INTERRUPT_ENABLE_REG, 8'h00}, 15);
      rdr(SIB_ADDR_INTERRUPT_ENABLE_REG, 8'h02);
      chk1(irq, 1'b1);
      wr(SIB_ADDR_INTERRUPT_ENABLE_REG, 8'h00);
      chk1(irq, 1'b0);
      finish_test();
   end
endmodule // sib_status_irq_bank_test
`default_nettype wire
